/* File: serial_channel_clock_select.sv */
// Purpose: two-channel transmitter/receiver clock selection
// Assumes: APB slave on CORE_CLK; OSC_IN is the oscillator pin
// Notes: tick outputs are 16X (or 1X) enables on CORE_CLK
//
// Functional notes
// - clock select byte: rx high, tx low
// - codes 0..12 pick generator rate
// - rate table per bank and extend
// - code 13 routes timer as 16X
// - code 14 pin 16X, 15 pin 1X
// - auxiliary bit 7 picks rate bank
// - each direction owns an extend bit
// - command 08/09 sets/clears rx extend
// - command 0A/0B sets/clears tx extend
// - generator ticks run at 16x rate
// - rates scale with oscillator frequency
// - 1X samples once, 16X oversamples start
// - midpoint after seven 16X ticks
// - then sample every sixteen ticks
// - after stop bit, hunt again
// - timer square wave feeds both channels
// - pin clocks come from pins 2..5
// - channel A: tx pin 3, rx pin 4
`timescale 1ns/1ps
`default_nettype none
module serial_channel_clock_select (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // ====================================================
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // ====================================================
  // clock sources
  input wire logic OSC_IN,
  input wire logic [3:0] INPUT_PINS,
  input wire logic TIMER_SQUARE,
  // ====================================================
  // serial lines and selected clocks
  input wire logic RXD_A,
  input wire logic RXD_B,
  output logic TX_A_TICK16,
  output logic TX_A_ONE_X,
  output logic TX_B_TICK16,
  output logic TX_B_ONE_X,
  output logic RX_A_MID,
  output logic RX_A_SAMPLE_STB,
  output logic RX_A_SAMPLE_BIT,
  output logic RX_A_DONE,
  output logic RX_B_MID,
  output logic RX_B_SAMPLE_STB,
  output logic RX_B_SAMPLE_BIT,
  output logic RX_B_DONE
);
  // ====================================================
  // declarations
  logic [6:0] sync1_q, sync2_q, prev_q;
  logic [6:0] rise;
  logic timer_prev_q;
  logic timer_tick;
  logic osc_tick;
  logic [7:0] csr_a_q, csr_a_d;
  logic [7:0] csr_b_q, csr_b_d;
  logic [7:0] aux_q, aux_d;
  logic [3:0] ext_q, ext_d;
  logic bank_q;
  logic [31:0] rdata_q, rdata_d;
  logic took_q;
  logic access, wr_en;
  logic hit_csr_a, hit_csr_b, hit_aux;
  logic hit_cmd_a, hit_cmd_b, hit_stat;
  logic addr_ok;
  logic [7:0] wbyte;
  logic [3:0] code_w [4];
  logic [3:0] pin_tick;
  clk_sel_if sel_if[4] ();

  // ====================================================
  // pin synchronisers and edge detect
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // rx lines start at their idle high level, so no false start follows reset
      sync1_q <= 7'h60;
      sync2_q <= 7'h60;
      prev_q <= 7'h60;
      timer_prev_q <= 1'b0;
    end else if (CLK_EN) begin
      sync1_q <= {RXD_B, RXD_A, INPUT_PINS, OSC_IN};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      timer_prev_q <= TIMER_SQUARE;
    end
  end

  assign rise = sync2_q & ~prev_q;
  // each oscillator rising edge advances the dividers
  assign osc_tick = rise[clk_sel_pkg::SYN_OSC];
  // the timer output is already on CORE_CLK
  assign timer_tick = TIMER_SQUARE && !timer_prev_q;

  // direction order: 0 rx A, 1 tx A, 2 rx B, 3 tx B
  assign pin_tick[0] = rise[clk_sel_pkg::SYN_PIN4];
  assign pin_tick[1] = rise[clk_sel_pkg::SYN_PIN3];
  assign pin_tick[2] = rise[clk_sel_pkg::SYN_PIN2];
  assign pin_tick[3] = rise[clk_sel_pkg::SYN_PIN5];

  // ====================================================
  // APB decode
  assign access = PSEL && PENABLE;
  assign wr_en = access && PWRITE && PREADY;
  assign wbyte = PWDATA[7:0];

  assign hit_csr_a = PADDR == clk_sel_pkg::OFS_CSR_A;
  assign hit_csr_b = PADDR == clk_sel_pkg::OFS_CSR_B;
  assign hit_aux = PADDR == clk_sel_pkg::OFS_AUX;
  assign hit_cmd_a = PADDR == clk_sel_pkg::OFS_CMD_A;
  assign hit_cmd_b = PADDR == clk_sel_pkg::OFS_CMD_B;
  assign hit_stat = PADDR == clk_sel_pkg::OFS_EXT_STAT;
  assign addr_ok = hit_csr_a || hit_csr_b || hit_aux ||
                   hit_cmd_a || hit_cmd_b || hit_stat;

  // ready once read data was captured during this transfer
  assign PREADY = CLK_EN && took_q;
  assign PSLVERR = access && PREADY && !addr_ok;
  assign PRDATA = rdata_q;

  // command registers read as zero
  assign rdata_d = hit_csr_a ? {24'h000000, csr_a_q} :
                   hit_csr_b ? {24'h000000, csr_b_q} :
                   hit_aux ? {24'h000000, aux_q} :
                   hit_stat ? {27'h0000000, bank_q, ext_q} :
                   32'h00000000;

  // ====================================================
  // register next values
  assign csr_a_d = (wr_en && hit_csr_a) ? wbyte : csr_a_q;
  assign csr_b_d = (wr_en && hit_csr_b) ? wbyte : csr_b_q;
  assign aux_d = (wr_en && hit_aux) ? wbyte : aux_q;
  assign bank_q = aux_q[clk_sel_pkg::BANK_BIT];

  // extend bits change only through command bytes
  always_comb begin
    ext_d = ext_q;
    if (wr_en && hit_cmd_a) begin
      case (wbyte)
        clk_sel_pkg::CMD_RX_EXT_SET: ext_d[0] = 1'b1;
        clk_sel_pkg::CMD_RX_EXT_CLR: ext_d[0] = 1'b0;
        clk_sel_pkg::CMD_TX_EXT_SET: ext_d[1] = 1'b1;
        clk_sel_pkg::CMD_TX_EXT_CLR: ext_d[1] = 1'b0;
        default: ext_d = ext_q;
      endcase
    end
    if (wr_en && hit_cmd_b) begin
      case (wbyte)
        clk_sel_pkg::CMD_RX_EXT_SET: ext_d[2] = 1'b1;
        clk_sel_pkg::CMD_RX_EXT_CLR: ext_d[2] = 1'b0;
        clk_sel_pkg::CMD_TX_EXT_SET: ext_d[3] = 1'b1;
        clk_sel_pkg::CMD_TX_EXT_CLR: ext_d[3] = 1'b0;
        default: ext_d = ext_q;
      endcase
    end
  end

  // ====================================================
  // registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      csr_a_q <= clk_sel_pkg::CSR_RESET;
      csr_b_q <= clk_sel_pkg::CSR_RESET;
      aux_q <= clk_sel_pkg::AUX_RESET;
      ext_q <= clk_sel_pkg::EXT_RESET;
    end else if (CLK_EN) begin
      csr_a_q <= csr_a_d;
      csr_b_q <= csr_b_d;
      aux_q <= aux_d;
      ext_q <= ext_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h00000000;
      took_q <= 1'b0;
    end else if (CLK_EN) begin
      rdata_q <= rdata_d;
      took_q <= PSEL;
    end
  end

  // ====================================================
  // per-direction selectors
  assign code_w[0] = csr_a_q[7:4];
  assign code_w[1] = csr_a_q[3:0];
  assign code_w[2] = csr_b_q[7:4];
  assign code_w[3] = csr_b_q[3:0];

  // separate dividers keep each direction independent
  for (genvar g = 0; g < 4; g++) begin : g_dir
    dir_clock_select u_sel (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .clk_en(CLK_EN),
      .code(code_w[g]),
      .bank(bank_q),
      .ext(ext_q[g]),
      .osc_tick(osc_tick),
      .timer_tick(timer_tick),
      .pin_tick(pin_tick[g]),
      .sel(sel_if[g])
    );
  end

  assign TX_A_TICK16 = sel_if[1].tick16;
  assign TX_A_ONE_X = sel_if[1].one_x;
  assign TX_B_TICK16 = sel_if[3].tick16;
  assign TX_B_ONE_X = sel_if[3].one_x;

  // ====================================================
  // receivers
  rx_start_sampler u_rx_a (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .clk_en(CLK_EN),
    .sel(sel_if[0]),
    .rx_line(sync2_q[clk_sel_pkg::SYN_RXD_A]),
    .mid_stb(RX_A_MID),
    .sample_stb(RX_A_SAMPLE_STB),
    .sample_bit(RX_A_SAMPLE_BIT),
    .done_stb(RX_A_DONE)
  );

  rx_start_sampler u_rx_b (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .clk_en(CLK_EN),
    .sel(sel_if[2]),
    .rx_line(sync2_q[clk_sel_pkg::SYN_RXD_B]),
    .mid_stb(RX_B_MID),
    .sample_stb(RX_B_SAMPLE_STB),
    .sample_bit(RX_B_SAMPLE_BIT),
    .done_stb(RX_B_DONE)
  );

  // ====================================================
  // checks
  sequence s_wr(logic hit, logic [7:0] val);
    wr_en && hit && wbyte == val;
  endsequence

  a_csr_store: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (wr_en && hit_csr_a) |=> csr_a_q == $past(wbyte) && code_w[0] == $past(wbyte[7:4]))
    else $error("clock select write not stored");

  a_bank_follow: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (wr_en && hit_aux) |=> bank_q == $past(wbyte[7]))
    else $error("rate bank does not follow bit 7");

  a_rx_ext_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    s_wr(hit_cmd_a, 8'h08) |=> ext_q[0] && $stable(ext_q[3:1]))
    else $error("rx extend not set");

  a_rx_ext_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    s_wr(hit_cmd_b, 8'h09) |=> !ext_q[2] && ext_q[1:0] == $past(ext_q[1:0]))
    else $error("rx extend not cleared");

  a_tx_ext_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    s_wr(hit_cmd_b, 8'h0A) |=> ext_q[3] && ext_q[1:0] == $past(ext_q[1:0]))
    else $error("tx extend not set");

  a_tx_ext_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    s_wr(hit_cmd_a, 8'h0B) |=> !ext_q[1] && ext_q[0] == $past(ext_q[0]))
    else $error("tx extend not cleared");

  a_ext_only_cmd: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (!(wr_en && (hit_cmd_a || hit_cmd_b))) |=> $stable(ext_q))
    else $error("extend bit changed without a command");

  a_reset_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(RST_N) |-> ext_q == 4'h0 && !bank_q)
    else $error("extend or bank bit set after reset");

  a_pin_one_x: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (CLK_EN && code_w[1] == 4'hF && $stable(code_w[1])) |=> TX_A_ONE_X)
    else $error("1X pin code not flagged");

  a_timer_route: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (CLK_EN && timer_tick && code_w[3] == 4'hD && $stable(code_w[3])) |=> TX_B_TICK16)
    else $error("timer tick not routed");

  a_err_unmapped: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (access && PREADY && PADDR == 8'h18) |-> PSLVERR)
    else $error("unmapped address not flagged");

  a_ready_access: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (access && CLK_EN && $past(PSEL) && $past(CLK_EN)) |-> PREADY)
    else $error("ready missing in access phase");

  a_unmapped_keep: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (access && PREADY && !addr_ok) |=> $stable(csr_a_q) && $stable(csr_b_q) && $stable(aux_q))
    else $error("unmapped write changed a register");

  a_stat_read: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (CLK_EN && hit_stat) |=> rdata_q == {27'h0000000, $past(bank_q), $past(ext_q)})
    else $error("extend status read wrong");

  a_freeze_regs: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (!CLK_EN) |=> $stable(csr_a_q) && $stable(csr_b_q) && $stable(aux_q) && $stable(ext_q))
    else $error("registers moved while clock enable low");

  a_pin_rx_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (CLK_EN && pin_tick[0] && code_w[0] == 4'hF && $stable(code_w[0])) |=> sel_if[0].tick16)
    else $error("receiver A pin tick not routed");

  a_pin_tx_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (CLK_EN && pin_tick[1] && code_w[1] == 4'hF && $stable(code_w[1])) |=> TX_A_TICK16)
    else $error("transmitter A pin tick not routed");
endmodule
`default_nettype wire

/* File: clk_sel_pkg.sv */
// Purpose: shared constants and rate lookup for the clock selectors
// Assumes: oscillator nominally 3.6864 MHz, sampled on the core clock
// Notes: divisors count oscillator edges per 16X tick
`default_nettype none
package clk_sel_pkg;
  // ====================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_CSR_A = 8'h00;
  localparam logic [7:0] OFS_CSR_B = 8'h04;
  localparam logic [7:0] OFS_AUX = 8'h08;
  localparam logic [7:0] OFS_CMD_A = 8'h0C;
  localparam logic [7:0] OFS_CMD_B = 8'h10;
  localparam logic [7:0] OFS_EXT_STAT = 8'h14;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [3:0] EXT_RESET = 4'h0;
  localparam int BANK_BIT = 7;
  // ====================================================
  // command bytes
  localparam logic [7:0] CMD_RX_EXT_SET = 8'h08;
  localparam logic [7:0] CMD_RX_EXT_CLR = 8'h09;
  localparam logic [7:0] CMD_TX_EXT_SET = 8'h0A;
  localparam logic [7:0] CMD_TX_EXT_CLR = 8'h0B;
  // ====================================================
  // nibble codes and receiver timing
  localparam logic [3:0] CODE_GEN_MAX = 4'hC;
  localparam logic [3:0] CODE_TIMER = 4'hD;
  localparam logic [3:0] CODE_PIN_1X = 4'hF;
  localparam logic [3:0] MID_TICKS = 4'h7;
  localparam logic [3:0] MID_LAST = MID_TICKS - 4'h1;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] FRAME_LAST = FRAME_BITS - 4'h1;
  // synchroniser bit positions: osc, pins 2..5, rx lines
  localparam int SYN_OSC = 0;
  localparam int SYN_PIN2 = 1;
  localparam int SYN_PIN3 = 2;
  localparam int SYN_PIN4 = 3;
  localparam int SYN_PIN5 = 4;
  localparam int SYN_RXD_A = 5;
  localparam int SYN_RXD_B = 6;
  typedef logic [12:0] div_t;
  // oscillator edges per 16X tick; bank and extend swap columns
  function automatic div_t rate_divisor(input logic [3:0] code,
                                        input logic bank, input logic ext);
    logic swap;
    swap = bank ^ ext;
    case (code)
      4'h0: rate_divisor = swap ? 13'h0C00 : 13'h1200;
      4'h1: rate_divisor = 13'h082F;
      4'h2: rate_divisor = 13'h06B1;
      4'h3: rate_divisor = swap ? 13'h0600 : 13'h0480;
      4'h4: rate_divisor = ext ? 13'h0040 : 13'h0300;
      4'h5: rate_divisor = ext ? 13'h0010 : 13'h0180;
      4'h6: rate_divisor = ext ? 13'h0008 : 13'h00C0;
      4'h7: rate_divisor = ext ? 13'h0004 : (bank ? 13'h0073 : 13'h00DB);
      4'h8: rate_divisor = ext ? 13'h0002 : 13'h0060;
      4'h9: rate_divisor = 13'h0030;
      4'hA: rate_divisor = swap ? 13'h0080 : 13'h0020;
      4'hB: rate_divisor = 13'h0018;
      4'hC: rate_divisor = swap ? 13'h000C : 13'h0006;
      default: rate_divisor = 13'h0001;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: clk_sel_if.sv */
// Purpose: selected clock of one direction
// Assumes: tick16 is a one-cycle enable pulse
// Notes: one_x marks an undivided pin clock
`timescale 1ns/1ps
`default_nettype none
interface clk_sel_if;
  logic tick16;
  logic one_x;
  modport src(output tick16, output one_x);
  modport snk(input tick16, input one_x);
endinterface
`default_nettype wire

/* File: dir_clock_select.sv */
// Purpose: clock source selection for one transmitter or receiver
// Assumes: tick inputs are one-cycle pulses on clk
// Notes: counter restarts whenever the nibble changes
`timescale 1ns/1ps
`default_nettype none
module dir_clock_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] code,
  input wire logic bank,
  input wire logic ext,
  input wire logic osc_tick,
  input wire logic timer_tick,
  input wire logic pin_tick,
  clk_sel_if.src sel
);
  clk_sel_pkg::div_t div_w;
  logic [12:0] cnt_q, cnt_d;
  logic [3:0] code_q;
  logic tick_q, one_x_q;
  logic from_gen, gen_hit, src_tick, changed;

  assign div_w = clk_sel_pkg::rate_divisor(code, bank, ext);
  assign from_gen = code <= clk_sel_pkg::CODE_GEN_MAX;
  assign changed = code != code_q;
  assign gen_hit = osc_tick && (cnt_q >= div_w - 13'h1);
  assign src_tick = from_gen ? gen_hit :
                    (code == clk_sel_pkg::CODE_TIMER) ? timer_tick : pin_tick;
  assign cnt_d = (changed || gen_hit) ? 13'h0000 :
                 osc_tick ? cnt_q + 13'h1 : cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 13'h0000;
      code_q <= 4'h0;
      tick_q <= 1'b0;
      one_x_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      code_q <= code;
      tick_q <= src_tick && !changed;
      one_x_q <= code == clk_sel_pkg::CODE_PIN_1X;
    end
  end

  assign sel.tick16 = tick_q;
  assign sel.one_x = one_x_q;

  a_switch_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && changed) |=> !tick_q)
    else $error("tick issued on a source switch");
endmodule
`default_nettype wire

/* File: rx_start_sampler.sv */
// Purpose: start-bit alignment and bit sampling for one receiver
// Assumes: rx_line already synchronised to clk
// Notes: frame is eight data bits, parity and stop
`timescale 1ns/1ps
`default_nettype none
module rx_start_sampler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  clk_sel_if.snk sel,
  input wire logic rx_line,
  output logic mid_stb,
  output logic sample_stb,
  output logic sample_bit,
  output logic done_stb
);
  typedef enum logic [1:0] {HUNT, ALIGN, FRAME} rx_state_t;
  rx_state_t state_q, state_d;
  logic [3:0] tick_cnt_q, tick_cnt_d, bit_cnt_q, bit_cnt_d;
  logic step, at_mid, at_bit, last_bit, mid_now;

  assign step = clk_en && sel.tick16;
  assign at_mid = (state_q == ALIGN) && (tick_cnt_q == clk_sel_pkg::MID_LAST);
  assign at_bit = (state_q == FRAME) &&
                  (sel.one_x || tick_cnt_q == clk_sel_pkg::TICK_LAST);
  assign last_bit = bit_cnt_q == clk_sel_pkg::FRAME_LAST;
  assign mid_now = !rx_line && (at_mid || (state_q == HUNT && sel.one_x));

  always_comb begin
    state_d = state_q;
    tick_cnt_d = tick_cnt_q + 4'h1;
    bit_cnt_d = bit_cnt_q;
    case (state_q)
      HUNT: begin
        tick_cnt_d = 4'h0;
        bit_cnt_d = 4'h0;
        if (!rx_line) begin
          state_d = sel.one_x ? FRAME : ALIGN;
        end
      end
      ALIGN: begin
        if (at_mid) begin
          tick_cnt_d = 4'h0;
          state_d = rx_line ? HUNT : FRAME;
        end
      end
      FRAME: begin
        if (at_bit) begin
          tick_cnt_d = 4'h0;
          bit_cnt_d = bit_cnt_q + 4'h1;
          if (last_bit) begin
            state_d = HUNT;
          end
        end
      end
      default: state_d = HUNT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HUNT;
      tick_cnt_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      mid_stb <= 1'b0;
      sample_stb <= 1'b0;
      sample_bit <= 1'b1;
      done_stb <= 1'b0;
    end else if (clk_en) begin
      mid_stb <= sel.tick16 && mid_now;
      sample_stb <= sel.tick16 && at_bit;
      done_stb <= sel.tick16 && at_bit && last_bit;
      if (sel.tick16) begin
        state_q <= state_d;
        tick_cnt_q <= tick_cnt_d;
        bit_cnt_q <= bit_cnt_d;
        if (at_bit) begin
          sample_bit <= rx_line;
        end
      end
    end
  end

  // ====================================================
  // checks
  sequence s_seventh_tick;
    step && state_q == ALIGN && tick_cnt_q == 4'h6 && !rx_line;
  endsequence
  sequence s_early_tick;
    step && state_q == FRAME && !sel.one_x && tick_cnt_q != 4'hF;
  endsequence

  a_mid_seven: assert property (@(posedge clk) disable iff (!rst_n)
    s_seventh_tick |=> mid_stb && state_q == FRAME)
    else $error("midpoint not taken on seventh tick");
  a_bit_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    s_early_tick |=> !sample_stb)
    else $error("16X sample before sixteenth tick");
  a_hunt_again: assert property (@(posedge clk) disable iff (!rst_n)
    done_stb |-> state_q == HUNT && $past(bit_cnt_q) == 4'h9)
    else $error("receiver not back to start search");
endmodule
`default_nettype wire

/* File: rx_line_source.sv */
// Purpose: far-side serial transmitter that drives a receiver line
// Assumes: tick_src rises once per 16X period, sampled on clk
// Notes: start, eight data bits lsb first, parity, stop; idle high
`timescale 1ns/1ps
`default_nettype none
module rx_line_source (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick_src,
  input wire logic go,
  input wire logic [7:0] data,
  input wire logic par,
  output logic line,
  output logic busy
);
  logic t_q;
  logic [3:0] cnt_q;
  logic [3:0] left_q;
  logic [8:0] sh_q;
  // ====================================================
  // framing: sixteen 16X ticks per bit, line idles at its pull-up level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t_q <= 1'b0;
      busy <= 1'b0;
      line <= 1'b1;
      cnt_q <= 4'h0;
      left_q <= 4'h0;
      sh_q <= 9'h000;
    end else begin
      t_q <= tick_src;
      if (go && !busy) begin
        busy <= 1'b1;
        line <= 1'b0;
        sh_q <= {par, data};
        left_q <= 4'hA;
        cnt_q <= 4'h0;
      end else if (busy && tick_src && !t_q) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'hF) begin
          left_q <= left_q - 4'h1;
          sh_q <= {1'b1, sh_q[8:1]};
          line <= (left_q == 4'h0) ? 1'b1 : sh_q[0];
          busy <= (left_q != 4'h0);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench for the two-channel clock selector
// Assumes: CLK_EN held high except during the final freeze check, channel B receive line idle
// Notes: oscillator and timer square wave are made from CORE_CLK
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] ex;} row_t;
  localparam logic [7:0] CA = clk_sel_pkg::OFS_CSR_A;
  localparam logic [7:0] CB = clk_sel_pkg::OFS_CSR_B;
  localparam logic [7:0] AX = clk_sel_pkg::OFS_AUX;
  localparam logic [7:0] MA = clk_sel_pkg::OFS_CMD_A;
  localparam logic [7:0] MB = clk_sel_pkg::OFS_CMD_B;
  localparam logic [7:0] ES = clk_sel_pkg::OFS_EXT_STAT;
  localparam row_t ROWS[13] = '{'{CA, 8'h88, CA, 8'h88}, '{CB, 8'hDD, CB, 8'hDD},
    '{AX, 8'h80, AX, 8'h80}, '{MA, 8'h08, ES, 8'h11}, '{MA, 8'h0A, ES, 8'h13},
    '{MB, 8'h08, ES, 8'h17}, '{MB, 8'h0A, ES, 8'h1F}, '{MA, 8'h09, ES, 8'h1E},
    '{MB, 8'h0B, ES, 8'h16}, '{AX, 8'h00, ES, 8'h06}, '{MA, 8'h0B, ES, 8'h04},
    '{MB, 8'h09, ES, 8'h00}, '{CA, 8'h5A, MA, 8'h00}};
  logic CORE_CLK, RST_N, PSEL, PENABLE, PWRITE, OSC_IN, TIMER_SQUARE, go, par, busy, line, err;
  logic cke;
  logic PREADY, PSLVERR, TX_A_TICK16, TX_A_ONE_X, TX_B_TICK16, RX_A_MID, RX_A_SAMPLE_STB;
  logic RX_A_SAMPLE_BIT, RX_A_DONE;
  logic [7:0] PADDR, dat;
  logic [3:0] pins;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [9:0] rx_sh = 10'h000;
  int errors = 0, n_compared = 0, div = 0, c_txa = 0, c_txb = 0, c_mid = 0, c_done = 0, n;
  serial_channel_clock_select uut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(cke),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .OSC_IN(OSC_IN), .INPUT_PINS(pins),
    .TIMER_SQUARE(TIMER_SQUARE), .RXD_A(line), .RXD_B(1'b1), .TX_A_TICK16(TX_A_TICK16),
    .TX_A_ONE_X(TX_A_ONE_X), .TX_B_TICK16(TX_B_TICK16), .TX_B_ONE_X(), .RX_A_MID(RX_A_MID),
    .RX_A_SAMPLE_STB(RX_A_SAMPLE_STB), .RX_A_SAMPLE_BIT(RX_A_SAMPLE_BIT), .RX_A_DONE(RX_A_DONE),
    .RX_B_MID(), .RX_B_SAMPLE_STB(), .RX_B_SAMPLE_BIT(), .RX_B_DONE());
  rx_line_source src (.clk(CORE_CLK), .rst_n(RST_N), .tick_src(TIMER_SQUARE), .go(go),
    .data(dat), .par(par), .line(line), .busy(busy));
  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  // ====================================================
  // source clocks, event counters and hang guard
  always @(posedge CORE_CLK) begin
    div <= div + 1;
    if (div % 5 == 4) OSC_IN <= ~OSC_IN;
    if (div % 4 == 3) TIMER_SQUARE <= ~TIMER_SQUARE;
    c_txa <= c_txa + int'(TX_A_TICK16);
    c_txb <= c_txb + int'(TX_B_TICK16);
    c_mid <= c_mid + int'(RX_A_MID);
    c_done <= c_done + int'(RX_A_DONE);
    if (RX_A_SAMPLE_STB) rx_sh <= {RX_A_SAMPLE_BIT, rx_sh[9:1]};
    if (div == 30000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 100);
    if (PREADY !== 1'b1) errors++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
  endtask
  task automatic pulse(input int idx);
    n = c_txa;
    repeat (4) begin
      pins[idx] <= 1'b1;
      repeat (8) @(posedge CORE_CLK);
      pins[idx] <= 1'b0;
      repeat (8) @(posedge CORE_CLK);
    end
    repeat (8) @(posedge CORE_CLK);
  endtask
  task automatic frame(input logic [7:0] d, input logic p);
    int k = 0;
    int m = c_mid;
    int e = c_done;
    dat <= d;
    par <= p;
    go <= 1'b1;
    @(posedge CORE_CLK);
    go <= 1'b0;
    do @(posedge CORE_CLK); while ((busy !== 1'b0 || k++ < 2) && k < 4000);
    chk(32'(rx_sh), {22'h0, 1'b1, p, d});
    chk(32'(c_mid - m), 32'h1);
    chk(32'(c_done - e), 32'h1);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {RST_N, PSEL, PENABLE, PWRITE, OSC_IN, TIMER_SQUARE, go, par} = 8'h00;
    {PADDR, dat, pins, PWDATA} = 52'h0;
    cke = 1'b1;
    repeat (12) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    @(posedge CORE_CLK);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0); chk(rd, 32'h0);
    end
    $display("reset values done");
    foreach (ROWS[i]) begin
      apb(1'b1, ROWS[i].wa, 32'(ROWS[i].wd));
      apb(1'b0, ROWS[i].ra, 32'h0); chk(rd, 32'(ROWS[i].ex));
    end
    apb(1'b1, 8'h18, 32'h77); chk({31'h0, err}, 32'h1);
    apb(1'b0, CA, 32'h0); chk(rd, 32'h5A);
    $display("register table done");
    apb(1'b1, CA, 32'hFF); chk({31'h0, TX_A_ONE_X}, 32'h1);
    pulse(1); chk(32'(c_txa - n), 32'h4);
    pulse(2); chk(32'(c_txa - n), 32'h0);
    apb(1'b1, CA, 32'hEE); chk({31'h0, TX_A_ONE_X}, 32'h0);
    $display("pin clocks done");
    apb(1'b1, CA, 32'hDD);
    frame(8'hA5, 1'b1);
    frame(8'h3C, 1'b0);
    $display("receiver frames done");
    apb(1'b1, CB, 32'h08);
    apb(1'b1, AX, 32'h80);
    apb(1'b1, MB, 32'h0A);
    n = c_txb;
    repeat (400) @(posedge CORE_CLK);
    chk(32'(c_txb - n >= 19 && c_txb - n <= 21), 32'h1);
    $display("generator rate done");
    cke <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    n = c_txb;
    repeat (100) @(posedge CORE_CLK);
    chk(32'(c_txb - n), TX_B_TICK16 ? 32'h64 : 32'h0);
    cke <= 1'b1;
    @(posedge CORE_CLK);
    $display("clock enable freeze done");
    conclude();
  end
endmodule
`default_nettype wire
